// *** logic/dcc_ctrl_top.sv ***
// Device control word and the gating it applies to target, master, error and interrupt paths
//
// Overview of operation
// - All-zero word detaches device except configuration, parity drive and interrupt pin
// - Bit 0 gates I/O target claims
// - Bit 1 gates memory target claims
// - Bit 2 gates initiating master transactions
// - Bit 3 gates special cycle monitoring
// - Bit 4 clear turns invalidate writes plain
// - Bit 5 with bit 1 snoops palette writes without claiming
// - Bit 6 clear suppresses parity error pin
// - Parity generated regardless of checking enable
// - Bit 7 hardwired zero, not writable
// - Bit 8 enables system error driver
// - Address parity reported only bits 8,6
// - Bit 9 permits fast back-to-back elsewhere
// - Bit 10 blocks legacy interrupt pin
// - Absent functions have no writable bit
// - Word resets to all zeros
// - Disable never alters internal interrupt flag
// - Reads return the value in use
`timescale 1ns/10ps
module dcc_ctrl_top #(
  parameter logic [15:0] IMPL_MASK = 16'h077f
) (
  input  wire logic               clock_in,
  input  wire logic               rst_n_in,
  input  wire logic               cfg_valid_in,
  input  wire dcc_pkg::dcc_cfg_s  cfg_in,
  output logic [15:0]             cfg_rdata_out,
  output logic                    cfg_ack_out,
  input  wire dcc_pkg::dcc_txn_s  txn_in,
  output logic                    claim_out,
  output logic                    snoop_out,
  output logic                    special_monitor_out,
  input  wire logic               master_req_in,
  input  wire dcc_pkg::dcc_cmd_e  master_cmd_in,
  input  wire logic               master_fbb_other_in,
  output logic                    master_req_out,
  output dcc_pkg::dcc_cmd_e       master_cmd_out,
  output logic                    master_fbb_out,
  input  wire logic               par_gen_in,
  output logic                    par_drive_out,
  input  wire dcc_pkg::dcc_err_s  err_in,
  output logic                    perr_n_out,
  output logic                    perr_oe_n_out,
  output logic                    serr_n_out,
  output logic                    serr_oe_n_out,
  output logic                    det_par_err_out,
  input  wire logic               int_pending_in,
  output logic                    int_status_out,
  output logic                    int_n_out,
  output logic                    int_oe_n_out
);
  import dcc_pkg::*;

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  logic [15:0] ctrl;
  logic        cfg_hit;
  logic        cfg_wr_en;
  logic        cfg_ack_ff;
  logic [15:0] cfg_rdata_ff;
  logic [15:0] nxt_rdata;
  logic        is_cfg_cmd;
  logic        io_en;
  logic        mem_en;
  logic        master_en;
  logic        special_en;
  logic        mwi_en;
  logic        snoop_en;
  logic        parity_en;
  logic        serr_en;
  logic        fbb_en;
  logic        int_dis;
  logic        detached;
  logic        nxt_claim;
  logic        nxt_snoop;
  logic        nxt_special;
  logic        claim_ff;
  logic        snoop_ff;
  logic        special_ff;
  logic        master_req_ff;
  dcc_cmd_e    master_cmd_ff;
  dcc_cmd_e    nxt_master_cmd;
  logic        master_fbb_ff;
  logic        par_drive_ff;
  logic        nxt_perr;
  logic        nxt_serr;
  logic        perr_ff;
  logic        serr_ff;
  logic        det_par_ff;
  logic        int_status_ff;
  logic        int_drive_ff;

  // -----------------------------------------------------------------
  // Control word storage
  // -----------------------------------------------------------------
  // Configuration accesses always decode, whatever the word holds
  assign cfg_hit   = cfg_valid_in && (cfg_in.offset == DCC_CTRL_OFFSET);
  assign cfg_wr_en = cfg_hit && cfg_in.wr;

  dcc_ctrl_reg #(
    .IMPL_MASK  (IMPL_MASK)
  ) u_ctrl_reg (
    .clock_in   (clock_in),
    .rst_n_in   (rst_n_in),
    .wr_en_in   (cfg_wr_en),
    .byte_en_in (cfg_in.byte_en),
    .wdata_in   (cfg_in.wdata),
    .ctrl_out   (ctrl)
  );

  // -----------------------------------------------------------------
  // Configuration read path
  // -----------------------------------------------------------------
  // Read returns live, masked word; other offsets read zero
  assign nxt_rdata = (cfg_hit && !cfg_in.wr) ? ctrl : 16'h0000;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cfg_ack_ff   <= 1'b0;
      cfg_rdata_ff <= 16'h0000;
    end else begin
      cfg_ack_ff   <= cfg_valid_in;
      cfg_rdata_ff <= nxt_rdata;
    end
  end

  assign cfg_ack_out   = cfg_ack_ff;
  assign cfg_rdata_out = cfg_rdata_ff;

  // -----------------------------------------------------------------
  // Field decode
  // -----------------------------------------------------------------
  assign io_en      = ctrl[DCC_IO_BIT];
  assign mem_en     = ctrl[DCC_MEM_BIT];
  assign master_en  = ctrl[DCC_MASTER_BIT];
  assign special_en = ctrl[DCC_SPECIAL_BIT];
  assign mwi_en     = ctrl[DCC_MWI_BIT];
  assign snoop_en   = ctrl[DCC_SNOOP_BIT];
  assign parity_en  = ctrl[DCC_PARITY_BIT];
  assign serr_en    = ctrl[DCC_SYSERR_BIT];
  assign fbb_en     = ctrl[DCC_FBB_BIT];
  assign int_dis    = ctrl[DCC_INTDIS_BIT];
  assign detached   = (ctrl == 16'h0000);

  // -----------------------------------------------------------------
  // Target claim decode
  // -----------------------------------------------------------------
  // Palette writes are watched, never claimed, while snooping
  assign is_cfg_cmd  = (txn_in.cmd == DCC_CMD_CFG_RD) || (txn_in.cmd == DCC_CMD_CFG_WR);
  assign nxt_snoop   = txn_in.valid && snoop_en && txn_in.palette_wr && mem_en;
  assign nxt_claim   = txn_in.valid && !is_cfg_cmd && !nxt_snoop
                       && ((io_en && txn_in.io_hit)
                       ||  (mem_en && txn_in.mem_hit));
  assign nxt_special = txn_in.valid && special_en && (txn_in.cmd == DCC_CMD_SPECIAL);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      claim_ff   <= 1'b0;
      snoop_ff   <= 1'b0;
      special_ff <= 1'b0;
    end else begin
      claim_ff   <= nxt_claim;
      snoop_ff   <= nxt_snoop;
      special_ff <= nxt_special;
    end
  end

  assign claim_out           = claim_ff;
  assign snoop_out           = snoop_ff;
  assign special_monitor_out = special_ff;

  // -----------------------------------------------------------------
  // Master gating
  // -----------------------------------------------------------------
  // Invalidate write downgraded when not permitted
  assign nxt_master_cmd = (master_cmd_in == DCC_CMD_MWI && !mwi_en) ? DCC_CMD_MEM_WR
                                                                    : master_cmd_in;

  // Request only leaves when mastering is enabled
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      master_req_ff <= 1'b0;
      master_cmd_ff <= DCC_CMD_MEM_WR;
      master_fbb_ff <= 1'b0;
    end else begin
      master_req_ff <= master_req_in && master_en;
      master_cmd_ff <= nxt_master_cmd;
      master_fbb_ff <= master_fbb_other_in && fbb_en;
    end
  end

  assign master_req_out = master_req_ff;
  assign master_cmd_out = master_cmd_ff;
  assign master_fbb_out = master_fbb_ff;

  // -----------------------------------------------------------------
  // Parity and system error
  // -----------------------------------------------------------------
  // Parity drive independent of checking enable
  assign nxt_perr = err_in.data_par_err && parity_en;
  assign nxt_serr = serr_en && (err_in.sys_err_req
                    || (err_in.addr_par_err && parity_en));

  // Detected-parity flag follows either parity error each cycle regardless of bit 6; it clears itself when both drop
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      par_drive_ff <= 1'b0;
      perr_ff      <= 1'b0;
      serr_ff      <= 1'b0;
      det_par_ff   <= 1'b0;
    end else begin
      par_drive_ff <= par_gen_in;
      perr_ff      <= nxt_perr;
      serr_ff      <= nxt_serr;
      det_par_ff   <= err_in.data_par_err || err_in.addr_par_err;
    end
  end

  assign par_drive_out   = par_drive_ff;
  assign det_par_err_out = det_par_ff;
  // Open-drain: enable low only while pulling low
  assign perr_n_out      = 1'b0;
  assign perr_oe_n_out   = !perr_ff;
  assign serr_n_out      = 1'b0;
  assign serr_oe_n_out   = !serr_ff;

  // -----------------------------------------------------------------
  // Legacy interrupt
  // -----------------------------------------------------------------
  // Status follows the source untouched by the disable bit
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      int_status_ff <= 1'b0;
      int_drive_ff  <= 1'b0;
    end else begin
      int_status_ff <= int_pending_in;
      int_drive_ff  <= int_pending_in && !int_dis;
    end
  end

  assign int_status_out = int_status_ff;
  assign int_n_out      = 1'b0;
  assign int_oe_n_out   = !int_drive_ff;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  chk_detached_no_claim : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    detached && $stable(ctrl) |=> !claim_out && !master_req_out)
    else $error("detached device acted on bus");
  chk_io_gate : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    txn_in.valid && txn_in.io_hit && !txn_in.mem_hit && !io_en |=> !claim_out)
    else $error("I/O claimed while disabled");
  chk_mem_gate : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    txn_in.valid && txn_in.mem_hit && !txn_in.io_hit && !mem_en |=> !claim_out)
    else $error("memory claimed while disabled");
  chk_master_gate : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    master_req_in && master_en |=> master_req_out)
    else $error("master request lost");
  chk_mwi_downgrade : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    master_cmd_in == DCC_CMD_MWI && !mwi_en |=> master_cmd_out == DCC_CMD_MEM_WR)
    else $error("invalidate write not downgraded");
  chk_perr_quiet : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    err_in.data_par_err && !parity_en |=> perr_oe_n_out && det_par_err_out)
    else $error("parity pin asserted while response off");
  chk_addr_par : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    err_in.addr_par_err && serr_en && parity_en |=> !serr_oe_n_out)
    else $error("address parity not reported");
  chk_int_block : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    int_pending_in && int_dis |=> int_oe_n_out && int_status_out)
    else $error("interrupt pin driven while disabled");
  chk_read_value : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cfg_hit && !cfg_in.wr |=> cfg_rdata_out == $past(ctrl) && cfg_rdata_out[15:11] == 5'h00)
    else $error("read value differs from word in use");
  chk_reset_zero : assert property (@(posedge clock_in)
    !rst_n_in |=> ctrl == 16'h0000)
    else $error("word not cleared by reset");

  // Configuration path answers whatever the word holds
  chk_cfg_answered : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cfg_valid_in |=> cfg_ack_out)
    else $error("configuration access not answered");
  chk_ack_pulse : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !cfg_valid_in |=> !cfg_ack_out)
    else $error("answer without an access");
  chk_write_rdata : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cfg_valid_in && cfg_in.wr |=> cfg_rdata_out == 16'h0000)
    else $error("write returned read data");
  chk_write_lands : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cfg_wr_en && cfg_in.byte_en == 2'b11
    |=> ctrl == ($past(cfg_in.wdata) & IMPL_MASK & ~DCC_RSVD_MASK & ~(16'h0001 << DCC_WAIT_BIT)))
    else $error("full write did not land as masked");

  // Target side gating
  chk_cfg_not_claimed : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    txn_in.valid && (txn_in.cmd == DCC_CMD_CFG_RD || txn_in.cmd == DCC_CMD_CFG_WR)
    |=> !claim_out)
    else $error("configuration command claimed as target");
  chk_detached_quiet : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    detached && $stable(ctrl) |=> !snoop_out && !special_monitor_out)
    else $error("detached device watched the bus");
  chk_special_gate : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    txn_in.valid && txn_in.cmd == DCC_CMD_SPECIAL |=> special_monitor_out == $past(special_en))
    else $error("special cycle monitor not following its enable");
  chk_snoop_no_claim : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    txn_in.valid && txn_in.palette_wr && snoop_en && mem_en |=> snoop_out && !claim_out)
    else $error("snooped palette write claimed");

  // Master side gating
  chk_master_block : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !master_en |=> !master_req_out)
    else $error("master request left while mastering off");
  chk_mwi_kept : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    master_cmd_in == DCC_CMD_MWI && mwi_en |=> master_cmd_out == DCC_CMD_MWI)
    else $error("permitted invalidate write downgraded");
  chk_fbb_gate : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    master_fbb_other_in && !fbb_en |=> !master_fbb_out)
    else $error("fast back-to-back elsewhere while disabled");

  // Parity and system error pins
  chk_par_kept : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    par_gen_in && !parity_en |=> par_drive_out)
    else $error("parity not driven while checking off");
  chk_perr_report : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    err_in.data_par_err && parity_en |=> !perr_oe_n_out)
    else $error("parity error pin not driven");
  chk_det_parity : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    err_in.data_par_err || err_in.addr_par_err |=> det_par_err_out)
    else $error("detected parity flag missing");
  chk_serr_off : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !serr_en |=> serr_oe_n_out)
    else $error("system error driver on while disabled");
  chk_serr_quiet : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    err_in.addr_par_err && !err_in.sys_err_req && !(serr_en && parity_en) |=> serr_oe_n_out)
    else $error("address parity reported without both enables");

  // Legacy interrupt pin and status
  chk_int_status : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    int_pending_in |=> int_status_out)
    else $error("interrupt status lost");
  chk_int_drive : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    int_pending_in && !int_dis |=> !int_oe_n_out)
    else $error("interrupt pin not driven while enabled");

endmodule

// *** logic/dcc_pkg.sv ***
// Package for the device control word block: offsets, field positions, reset values, carriers
package dcc_pkg;

  // -----------------------------------------------------------------
  // Register map and field layout
  // -----------------------------------------------------------------
  localparam int unsigned     DCC_WIDTH        = 16;
  localparam logic [7:0]      DCC_CTRL_OFFSET  = 8'h04;
  localparam int unsigned     DCC_IO_BIT       = 0;
  localparam int unsigned     DCC_MEM_BIT      = 1;
  localparam int unsigned     DCC_MASTER_BIT   = 2;
  localparam int unsigned     DCC_SPECIAL_BIT  = 3;
  localparam int unsigned     DCC_MWI_BIT      = 4;
  localparam int unsigned     DCC_SNOOP_BIT    = 5;
  localparam int unsigned     DCC_PARITY_BIT   = 6;
  localparam int unsigned     DCC_WAIT_BIT     = 7;
  localparam int unsigned     DCC_SYSERR_BIT   = 8;
  localparam int unsigned     DCC_FBB_BIT      = 9;
  localparam int unsigned     DCC_INTDIS_BIT   = 10;
  localparam logic [15:0]     DCC_CTRL_RESET   = 16'h0000;
  localparam logic [15:0]     DCC_RSVD_MASK    = 16'hf800;

  // -----------------------------------------------------------------
  // Bus commands seen on the local bus
  // -----------------------------------------------------------------
  typedef enum logic [3:0] {
    DCC_CMD_SPECIAL   = 4'h1,
    DCC_CMD_IO_RD     = 4'h2,
    DCC_CMD_IO_WR     = 4'h3,
    DCC_CMD_MEM_RD    = 4'h6,
    DCC_CMD_MEM_WR    = 4'h7,
    DCC_CMD_CFG_RD    = 4'ha,
    DCC_CMD_CFG_WR    = 4'hb,
    DCC_CMD_MWI       = 4'hf
  } dcc_cmd_e;

  // Configuration access carrier
  typedef struct packed {
    logic        wr;
    logic [7:0]  offset;
    logic [1:0]  byte_en;
    logic [15:0] wdata;
  } dcc_cfg_s;

  // Incoming transaction decode carrier
  typedef struct packed {
    logic       valid;
    dcc_cmd_e   cmd;
    logic       io_hit;
    logic       mem_hit;
    logic       palette_wr;
  } dcc_txn_s;

  // Error event carrier
  typedef struct packed {
    logic data_par_err;
    logic addr_par_err;
    logic sys_err_req;
  } dcc_err_s;

endpackage

// *** logic/dcc_ctrl_reg.sv ***
// Storage element for the device control word with feature-dependent bit presence
`timescale 1ns/10ps
module dcc_ctrl_reg #(
  parameter logic [15:0] IMPL_MASK = 16'h077f
) (
  input  wire logic                      clock_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      wr_en_in,
  input  wire logic [1:0]                byte_en_in,
  input  wire logic [dcc_pkg::DCC_WIDTH-1:0] wdata_in,
  output logic      [dcc_pkg::DCC_WIDTH-1:0] ctrl_out
);
  import dcc_pkg::*;

  logic [DCC_WIDTH-1:0] ctrl_ff;
  logic [DCC_WIDTH-1:0] lane_mask;
  logic [DCC_WIDTH-1:0] wr_mask;
  logic [DCC_WIDTH-1:0] nxt_ctrl;

  // -----------------------------------------------------------------
  // Write merge
  // -----------------------------------------------------------------
  // Only implemented, unreserved, enabled lanes take data
  assign lane_mask = {{8{byte_en_in[1]}}, {8{byte_en_in[0]}}};
  assign wr_mask   = lane_mask & IMPL_MASK & ~DCC_RSVD_MASK
                     & ~(16'h0001 << DCC_WAIT_BIT);
  assign nxt_ctrl  = (ctrl_ff & ~wr_mask) | (wdata_in & wr_mask);

  // Cleared by bus reset
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ctrl_ff <= DCC_CTRL_RESET;
    end else if (wr_en_in) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Absent bits are constant zero, not storage
  assign ctrl_out = ctrl_ff & IMPL_MASK & ~DCC_RSVD_MASK & ~(16'h0001 << DCC_WAIT_BIT);

  chk_absent_zero : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (ctrl_out & ~IMPL_MASK) == 16'h0000) else $error("absent control bit set");
  chk_wait_zero : assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ctrl_out[DCC_WAIT_BIT] == 1'b0) else $error("bit 7 not zero");

endmodule

// *** tb/dcc_host_model.sv ***
// Host bridge model that issues configuration accesses to the control word
`timescale 1ns/10ps
module dcc_host_model
  import dcc_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic         cfg_ack_in,
  input  wire logic [15:0]  cfg_rdata_in,
  output logic              cfg_valid_out,
  output dcc_pkg::dcc_cfg_s cfg_out
);
  // Idle from time zero so the strobe is never unknown
  initial begin
    cfg_valid_out = 1'b0;
    cfg_out = '0;
  end

  // ---------------------------------------------------------------
  // One access: a one-cycle strobe, the answer taken a cycle later
  // ---------------------------------------------------------------
  task automatic access(input logic wr, input logic [7:0] off, input logic [1:0] be,
                        input logic [15:0] wd, output logic [15:0] rd, output logic ok);
    @(posedge clock_in);
    #1;
    cfg_valid_out = 1'b1;
    cfg_out = '{wr: wr, offset: off, byte_en: be, wdata: wd};
    @(posedge clock_in);
    #1;
    ok = cfg_ack_in;    // Ack stands one cycle only
    rd = cfg_rdata_in;
    cfg_valid_out = 1'b0;
    // Released bus shows the inverse, so stale fields cannot pass as live
    cfg_out = '{wr: ~wr, offset: ~off, byte_en: ~be, wdata: ~wd};
  endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the device control word and its gating
`timescale 1ns/10ps
module tb;
  import dcc_pkg::*;
  localparam logic [15:0] IMPL = 16'h077f;
  localparam logic [15:0] WMASK = IMPL & ~DCC_RSVD_MASK & ~16'h0080;
  logic        clock_in, rst_n_in, cfg_valid_in, cfg_ack_out, claim_out, snoop_out;
  logic        special_monitor_out, master_req_in, master_fbb_other_in, master_req_out;
  logic        master_fbb_out, par_gen_in, par_drive_out, perr_n_out, perr_oe_n_out;
  logic        serr_n_out, serr_oe_n_out, det_par_err_out, int_pending_in, int_status_out;
  logic        int_n_out, int_oe_n_out, ok;
  logic [15:0] cfg_rdata_out, rd, w;
  dcc_cfg_s    cfg_in;
  dcc_txn_s    txn_in;
  dcc_err_s    err_in;
  dcc_cmd_e    master_cmd_in, master_cmd_out;
  int          fail_count, n_checks;
  dcc_cmd_e    cmds [8] = '{DCC_CMD_SPECIAL, DCC_CMD_IO_RD, DCC_CMD_IO_WR, DCC_CMD_MEM_RD,
                            DCC_CMD_MEM_WR, DCC_CMD_CFG_RD, DCC_CMD_CFG_WR, DCC_CMD_MWI};
  // Bit 9 is set in two words: alone in 16'h0200 and with all fields in 16'h07ff
  logic [15:0] words [15] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010,
                              16'h0020, 16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h0400,
                              16'h0022, 16'h0140, 16'h07ff};

  // Design and host model
  dcc_ctrl_top #(.IMPL_MASK(IMPL)) dut_u (
    .clock_in, .rst_n_in, .cfg_valid_in, .cfg_in, .cfg_rdata_out, .cfg_ack_out, .txn_in,
    .claim_out, .snoop_out, .special_monitor_out, .master_req_in, .master_cmd_in,
    .master_fbb_other_in, .master_req_out, .master_cmd_out, .master_fbb_out, .par_gen_in,
    .par_drive_out, .err_in, .perr_n_out, .perr_oe_n_out, .serr_n_out, .serr_oe_n_out,
    .det_par_err_out, .int_pending_in, .int_status_out, .int_n_out, .int_oe_n_out);
  dcc_host_model host_u (.clock_in, .cfg_ack_in(cfg_ack_out), .cfg_rdata_in(cfg_rdata_out),
                         .cfg_valid_out(cfg_valid_in), .cfg_out(cfg_in));

  // 100 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Write, keeping a model of what the word should now hold
  task automatic wr_word(input logic [7:0] off, input logic [1:0] be, input logic [15:0] d);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}};
    host_u.access(1'b1, off, be, d, rd, ok);
    check({15'h0, ok, rd}, {15'h0, 1'b1, 16'h0000}, "write ack");
    if (off == DCC_CTRL_OFFSET)
      w = (w & ~lanes) | (d & lanes & WMASK);
  endtask

  task automatic rd_word(input logic [7:0] off, input logic [15:0] exp);
    host_u.access(1'b0, off, 2'b11, 16'h0000, rd, ok);
    check({15'h0, ok, rd}, {15'h0, 1'b1, exp}, "read");
  endtask

  // Drive one stimulus pattern, compare every gated output a cycle later
  task automatic probe(input logic [3:0] i);
    dcc_cmd_e c;
    logic     sn;
    logic     cl;
    logic     sp;
    c = cmds[i[2:0]];
    @(posedge clock_in);
    #1;
    txn_in = '{valid: i != 4, cmd: c, io_hit: ~i[3], mem_hit: i[3] | i[2], palette_wr: i[3]};
    master_req_in = i[0];
    master_cmd_in = c;
    master_fbb_other_in = i[1];
    err_in = '{data_par_err: i[1], addr_par_err: i[2], sys_err_req: i[3]};
    int_pending_in = i[0];
    par_gen_in = i[2];
    sn = txn_in.valid & w[5] & w[1] & i[3];
    cl = txn_in.valid & !(c inside {DCC_CMD_CFG_RD, DCC_CMD_CFG_WR}) & !sn
         & ((w[0] & ~i[3]) | (w[1] & (i[3] | i[2])));
    sp = txn_in.valid & w[3] & (c == DCC_CMD_SPECIAL);
    @(posedge clock_in);
    #1;
    check({14'h0, claim_out, snoop_out, special_monitor_out, master_req_out, master_cmd_out,
           master_fbb_out, par_drive_out, perr_oe_n_out, serr_oe_n_out, det_par_err_out,
           int_status_out, int_oe_n_out, perr_n_out, serr_n_out, int_n_out},
          {14'h0, cl, sn, sp, i[0] & w[2],
           (c == DCC_CMD_MWI && !w[4]) ? DCC_CMD_MEM_WR : c, i[1] & w[9], i[2],
           ~(i[1] & w[6]), ~(w[8] & (i[3] | (i[2] & w[6]))), i[1] | i[2],
           i[0], ~(i[0] & ~w[10]), 3'b000},
          "gated outputs");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog: the tests need well under 2,000 cycles
  initial begin
    #200000;
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n_in, master_req_in, master_fbb_other_in, par_gen_in, int_pending_in} = '0;
    txn_in = '0;
    err_in = '0;
    master_cmd_in = DCC_CMD_MEM_WR;
    fail_count = 0;
    n_checks = 0;
    w = 16'h0000;
    repeat (8) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    check({29'h0, perr_oe_n_out, serr_oe_n_out, int_oe_n_out}, 32'h7, "idle enables");
    rd_word(DCC_CTRL_OFFSET, 16'h0000);
    $display("test reset done");
    // Each word, then every stimulus pattern under it
    foreach (words[k]) begin
      wr_word(DCC_CTRL_OFFSET, 2'b11, words[k]);
      rd_word(DCC_CTRL_OFFSET, w);
      for (int i = 0; i < 16; i++)
        probe(4'(i));
    end
    $display("test gating done");
    // Refused bits, byte lanes and a foreign offset
    wr_word(DCC_CTRL_OFFSET, 2'b11, 16'hffff);
    rd_word(DCC_CTRL_OFFSET, 16'h077f);
    wr_word(DCC_CTRL_OFFSET, 2'b01, 16'h0000);
    rd_word(DCC_CTRL_OFFSET, 16'h0700);
    wr_word(8'h08, 2'b11, 16'h0000);
    rd_word(DCC_CTRL_OFFSET, 16'h0700);
    rd_word(8'h08, 16'h0000);
    $display("test lanes done");
    // Second reset in mid-run clears the word
    @(posedge clock_in);
    #1;
    rst_n_in = 1'b0;
    repeat (2) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    w = 16'h0000;
    rd_word(DCC_CTRL_OFFSET, 16'h0000);
    probe(4'h3);
    $display("test rereset done");
    wrap_up();
  end
endmodule
